// [core/dss_map.svh]
// constants of the display supply sequencer: offsets, fields, counts
// assumes a 100 MHz system clock and a plain register port
`ifndef DSS_MAP_SVH
`define DSS_MAP_SVH
// ***************************************************************
// clock and oscillator
// ***************************************************************
`define DSS_CLK_HZ         100000000
`define DSS_OSC_SLOW_HZ    500000
`define DSS_OSC_FAST_HZ    1000000
`define DSS_DIV_SLOW       (`DSS_CLK_HZ / `DSS_OSC_SLOW_HZ)
`define DSS_DIV_FAST       (`DSS_CLK_HZ / `DSS_OSC_FAST_HZ)
// ***************************************************************
// soft-start and pump stage counts, in oscillator cycles
// ***************************************************************
`define DSS_SS_PHASE_MS    1
`define DSS_SS_PHASE_SLOW  (`DSS_SS_PHASE_MS * `DSS_OSC_SLOW_HZ / 1000)
`define DSS_SS_PHASE_FAST  (`DSS_SS_PHASE_MS * `DSS_OSC_FAST_HZ / 1000)
`define DSS_SS_FULL_CYC    3072
`define DSS_PUMP_STAGE_CYC 4096
`define DSS_LIM_FIRST      2'h0
`define DSS_LIM_LAST_STEP  2'h2
`define DSS_LIM_FULL       2'h3
// ***************************************************************
// registers
// ***************************************************************
`define DSS_CTRL_ADDR      8'h00
`define DSS_STAT_ADDR      8'h04
`define DSS_CTRL_RST       8'h00
`define DSS_CTRL_NOPUMP    0
`define DSS_CTRL_FAST      1
// ***************************************************************
// synchronised pin inputs
// ***************************************************************
`define DSS_IN_SHUT        0
`define DSS_IN_MAIN_LOW    1
`define DSS_IN_TRIP        2
`define DSS_IN_PWM         3
`define DSS_IN_NEG_OK      4
`define DSS_IN_POS_OK      5
`define DSS_IN_FAULT       6
`define DSS_IN_BOOST_REG   7
`define DSS_IN_NUM         8
`endif

// [core/dss_osc_div.sv]
// internal oscillator: one-cycle tick and pump half-cycle phase
// assumes clk at 100 MHz and a synchronous active-high reset
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_osc_div (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // oscillator outputs
  dss_osc_if.src    osc
);
  logic [7:0] cnt_q, cnt_d;
  logic       tick_q, tick_d;
  logic       half_q, half_d;
  logic [7:0] last;

  // ***************************************************************
  // divider
  // ***************************************************************
  always_comb begin
    last   = osc.osc_fast ? 8'(`DSS_DIV_FAST - 1) : 8'(`DSS_DIV_SLOW - 1);
    tick_d = (cnt_q >= last);
    cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
    half_d = tick_d ? ~half_q : half_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
      half_q <= half_d;
    end
  end

  assign osc.osc_tick  = tick_q;
  assign osc.pump_half = half_q;
endmodule // dss_osc_div

// [core/dss_osc_if.sv]
// oscillator tick and pump phase shared inside the sequencer
// assumes one clock for all users
`timescale 1ns/1ps
interface dss_osc_if;
  logic osc_tick;
  logic pump_half;
  logic osc_fast;
  modport src (input osc_fast, output osc_tick, output pump_half);
  modport snk (input osc_fast, input osc_tick, input pump_half);
endinterface

// [core/dss_pkg.sv]
// types of the display supply sequencer
// assumes nothing of its surroundings
package dss_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_REF, ST_BOOST, ST_NEG, ST_POS, ST_READY, ST_FAULT
  } dss_state_type;
  typedef logic [1:0] dss_limit_type;
endpackage

// [core/dss_sequencer.sv]
// display supply sequencer top: boost switch latch, pump phases,
// shutdown, power-up order, fault latch, ready and a small register port
// assumes asynchronous comparator pins and a same-clock register master
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_sequencer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // comparator and control pins
  input  wire logic       shutdown_low_input,
  input  wire logic       main_low_cmp,
  input  wire logic       current_trip_cmp,
  input  wire logic       pwm_cmp,
  input  wire logic       neg_pump_feedback_ok,
  input  wire logic       pos_pump_feedback_ok,
  input  wire logic       fault_cmp,
  input  wire logic       boost_in_reg,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // supply enables
  output logic            ref_enable,
  output logic            boost_enable,
  output logic            ldo_enable,
  output logic            boost_switch_on,
  output logic      [1:0] current_limit_sel,
  output logic            full_switch_current_limit,
  // charge pumps
  output logic            neg_pump_enable,
  output logic            pos_pump_enable,
  output logic            pos_pump_low_on,
  output logic            pos_pump_high_on,
  output logic            neg_pump_high_on,
  output logic            neg_pump_low_on,
  // ready and buffer
  output logic            ready_low_out,
  output logic            ready_low_oe,
  output logic            backplane_buffer_enable
);
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [`DSS_IN_NUM-1:0] pin_in, meta_q, sync_q;
  assign pin_in = {boost_in_reg, fault_cmp, pos_pump_feedback_ok,
                   neg_pump_feedback_ok, pwm_cmp, current_trip_cmp,
                   main_low_cmp, shutdown_low_input};
  for (genvar i = 0; i < `DSS_IN_NUM; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  logic shut_s, main_low_s, trip_s, pwm_s, neg_ok_s, pos_ok_s;
  logic fault_s, breg_s;
  assign shut_s     = sync_q[`DSS_IN_SHUT];
  assign main_low_s = sync_q[`DSS_IN_MAIN_LOW];
  assign trip_s     = sync_q[`DSS_IN_TRIP];
  assign pwm_s      = sync_q[`DSS_IN_PWM];
  assign neg_ok_s   = sync_q[`DSS_IN_NEG_OK];
  assign pos_ok_s   = sync_q[`DSS_IN_POS_OK];
  assign fault_s    = sync_q[`DSS_IN_FAULT];
  assign breg_s     = sync_q[`DSS_IN_BOOST_REG];

  // ***************************************************************
  // oscillator and soft-start
  // ***************************************************************
  logic [7:0] ctrl_q, ctrl_d;
  logic       nopump;
  logic       ss_full;
  logic [1:0] ss_lim;
  logic       boost_en_q, boost_en_d;
  dss_osc_if osc ();
  assign osc.osc_fast = ctrl_q[`DSS_CTRL_FAST];
  assign nopump       = ctrl_q[`DSS_CTRL_NOPUMP];
  dss_osc_div u_osc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .osc     (osc)
  );
  dss_soft_start u_ss (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .osc       (osc),
    .run       (boost_en_q),
    .in_reg    (breg_s),
    .limit_sel (ss_lim),
    .full      (ss_full)
  );
  assign current_limit_sel         = ss_lim;
  assign full_switch_current_limit = ss_full;

  // ***************************************************************
  // sequencer
  // ***************************************************************
  dss_pkg::dss_state_type state_q, state_d;
  logic [11:0] stage_q, stage_d;
  logic        fault_q, fault_d;
  logic        shut_prev_q, pwm_prev_q;
  logic        shut_edge, stage_end;
  logic        ref_en_q, ref_en_d, neg_en_q, neg_en_d, pos_en_q, pos_en_d;
  logic        rdy_oe_q, rdy_oe_d;
  assign shut_edge = shut_s != shut_prev_q;
  assign stage_end = osc.osc_tick &&
                     stage_q == 12'(`DSS_PUMP_STAGE_CYC - 1);
  always_comb begin
    state_d = state_q;
    stage_d = stage_q;
    fault_d = fault_q;
    if (shut_edge) begin
      fault_d = 1'b0;
    end
    if (!shut_s) begin
      state_d = dss_pkg::ST_OFF;
      stage_d = 12'h000;
    end else begin
      case (state_q)
        dss_pkg::ST_OFF: begin
          state_d = dss_pkg::ST_REF;
        end
        dss_pkg::ST_REF: begin
          if (osc.osc_tick) begin
            state_d = dss_pkg::ST_BOOST;
          end
        end
        dss_pkg::ST_BOOST: begin
          if (pwm_s != pwm_prev_q) begin
            state_d = dss_pkg::ST_NEG;
            stage_d = 12'h000;
          end
        end
        dss_pkg::ST_NEG: begin
          if (osc.osc_tick) begin
            stage_d = stage_q + 12'h001;
          end
          if (nopump ? stage_end : neg_ok_s) begin
            state_d = dss_pkg::ST_POS;
            stage_d = 12'h000;
          end
        end
        dss_pkg::ST_POS: begin
          if (osc.osc_tick) begin
            stage_d = stage_q + 12'h001;
          end
          if (nopump ? stage_end : pos_ok_s) begin
            state_d = dss_pkg::ST_READY;
          end
        end
        dss_pkg::ST_READY: begin
          if (fault_s) begin
            state_d = dss_pkg::ST_FAULT;
            fault_d = 1'b1;
          end
        end
        dss_pkg::ST_FAULT: begin
          if (shut_edge) begin
            state_d = dss_pkg::ST_REF;
          end
        end
        default: begin
          state_d = dss_pkg::ST_OFF;
        end
      endcase
    end
    // enables follow the state and, for the pumps, the no-pump bit, never the regulator
    ref_en_d   = state_d != dss_pkg::ST_OFF;
    boost_en_d = state_d inside {dss_pkg::ST_BOOST, dss_pkg::ST_NEG,
                                 dss_pkg::ST_POS, dss_pkg::ST_READY};
    neg_en_d   = !nopump && state_d inside {dss_pkg::ST_NEG,
                                 dss_pkg::ST_POS, dss_pkg::ST_READY};
    pos_en_d   = !nopump && state_d inside {dss_pkg::ST_POS,
                                 dss_pkg::ST_READY};
    rdy_oe_d   = state_d == dss_pkg::ST_READY;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= dss_pkg::ST_OFF;
      stage_q     <= 12'h000;
      fault_q     <= 1'b0;
      shut_prev_q <= 1'b0;
      pwm_prev_q  <= 1'b0;
      ref_en_q    <= 1'b0;
      boost_en_q  <= 1'b0;
      neg_en_q    <= 1'b0;
      pos_en_q    <= 1'b0;
      rdy_oe_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      stage_q     <= stage_d;
      fault_q     <= fault_d;
      shut_prev_q <= shut_s;
      pwm_prev_q  <= pwm_s;
      ref_en_q    <= ref_en_d;
      boost_en_q  <= boost_en_d;
      neg_en_q    <= neg_en_d;
      pos_en_q    <= pos_en_d;
      rdy_oe_q    <= rdy_oe_d;
    end
  end

  // ***************************************************************
  // boost switch latch and pump drivers
  // ***************************************************************
  logic sw_q, sw_d, sw_set;
  logic [3:0] drv_q, drv_d;
  always_comb begin
    sw_set = osc.osc_tick && main_low_s && boost_en_q;
    sw_d   = sw_q;
    if (trip_s || !boost_en_d) begin
      sw_d = 1'b0;
    end else if (sw_set) begin
      sw_d = 1'b1;
    end
    drv_d[0] = pos_en_d && !osc.pump_half;
    drv_d[1] = pos_en_d && osc.pump_half;
    drv_d[2] = neg_en_d && !osc.pump_half;
    drv_d[3] = neg_en_d && osc.pump_half;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_q  <= 1'b0;
      drv_q <= 4'h0;
    end else begin
      sw_q  <= sw_d;
      drv_q <= drv_d;
    end
  end

  // ***************************************************************
  // register port
  // ***************************************************************
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_addr == `DSS_CTRL_ADDR) begin
      ctrl_d = reg_wdata & 8'h03;
    end
    if (reg_rd) begin
      case (reg_addr)
        `DSS_CTRL_ADDR: rdata_d = ctrl_q;
        `DSS_STAT_ADDR: rdata_d = {1'b0, rdy_oe_q, fault_q, ss_lim,
                                   3'(state_q)};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q  <= `DSS_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign ref_enable              = ref_en_q;
  assign boost_enable            = boost_en_q;
  assign ldo_enable              = boost_en_q;
  assign boost_switch_on         = sw_q;
  assign neg_pump_enable         = neg_en_q;
  assign pos_pump_enable         = pos_en_q;
  assign pos_pump_low_on         = drv_q[0];
  assign pos_pump_high_on        = drv_q[1];
  assign neg_pump_high_on        = drv_q[2];
  assign neg_pump_low_on         = drv_q[3];
  assign ready_low_out           = 1'b0;
  assign ready_low_oe            = rdy_oe_q;
  assign backplane_buffer_enable = rdy_oe_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  switch_set_a: assert property (sw_set && !trip_s && boost_en_d |=>
                                 sw_q)
    else $error("switch not set on oscillator edge");
  trip_off_a: assert property (trip_s |=> !sw_q)
    else $error("switch still on after current trip");
  skip_start_a: assert property ($rose(sw_q) |-> $past(osc.osc_tick)
                                 && $past(main_low_s))
    else $error("switch cycle started without low output");
  pump_rate_a: assert property ($changed(osc.pump_half) |-> osc.osc_tick)
    else $error("pump phase moved off the oscillator tick");
  pos_excl_a: assert property (!(drv_q[0] && drv_q[1]))
    else $error("positive pump switches overlap");
  neg_phase_a: assert property (drv_q[2] |-> !drv_q[3] && neg_en_q)
    else $error("negative pump phase wrong");
  shut_off_a: assert property (!shut_s |=> !ref_en_q && !boost_en_q
                               && !sw_q && !rdy_oe_q)
    else $error("outputs active in shutdown");
  fault_clr_a: assert property (shut_edge |=> !fault_q)
    else $error("fault latch kept over shutdown edge");
  ref_first_a: assert property ($rose(boost_en_q) |-> $past(ref_en_q))
    else $error("boost enabled before reference");
  neg_start_a: assert property ($rose(neg_en_q) |->
                                $past(state_q) == dss_pkg::ST_BOOST)
    else $error("negative pump started out of order");
  ready_buf_a: assert property ($rose(rdy_oe_q) |->
                                backplane_buffer_enable
                                && $past(state_q) == dss_pkg::ST_POS)
    else $error("ready rose out of order or without buffer");
  fault_rel_a: assert property (state_q == dss_pkg::ST_READY && fault_s
                                && shut_s |=> !rdy_oe_q && ref_en_q
                                && !boost_en_q && fault_q)
    else $error("fault did not release outputs");
  ready_c: cover property ($rose(rdy_oe_q));
  fault_c: cover property (state_q == dss_pkg::ST_FAULT ##1
                           state_q == dss_pkg::ST_REF);
  skip_c: cover property (osc.osc_tick && boost_en_q && !main_low_s);
endmodule // dss_sequencer

// [core/dss_soft_start.sv]
// boost soft-start: four current-limit phases stepped by oscillator
// assumes run falls whenever shutdown or the fault latch stops the boost
`timescale 1ns/1ps
`include "dss_map.svh"
module dss_soft_start (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // oscillator
  dss_osc_if.snk                 osc,
  // control
  input  wire logic              run,
  input  wire logic              in_reg,
  // limit selection
  output dss_pkg::dss_limit_type limit_sel,
  output logic                   full
);
  logic [10:0]           ph_cnt_q, ph_cnt_d;
  logic [11:0]           tot_q, tot_d;
  dss_pkg::dss_limit_type phase_q, phase_d, lim_q, lim_d;
  logic                  full_q, full_d;
  logic [10:0]           plen;

  // ***************************************************************
  // phase stepper
  // ***************************************************************
  always_comb begin
    plen     = osc.osc_fast ? 11'(`DSS_SS_PHASE_FAST - 1)
                            : 11'(`DSS_SS_PHASE_SLOW - 1);
    ph_cnt_d = ph_cnt_q;
    tot_d    = tot_q;
    phase_d  = phase_q;
    full_d   = full_q;
    if (!run) begin
      ph_cnt_d = 11'h000;
      tot_d    = 12'h000;
      phase_d  = `DSS_LIM_FIRST;
      full_d   = 1'b0;
    end else begin
      if (in_reg) begin
        full_d = 1'b1;
      end
      if (osc.osc_tick && !full_q) begin
        tot_d = tot_q + 12'h001;
        if (tot_q == 12'(`DSS_SS_FULL_CYC - 1)) begin
          full_d = 1'b1;
        end
        if (ph_cnt_q >= plen) begin
          ph_cnt_d = 11'h000;
          if (phase_q != `DSS_LIM_LAST_STEP && !in_reg) begin
            phase_d = phase_q + 2'h1;
          end
        end else begin
          ph_cnt_d = ph_cnt_q + 11'h001;
        end
      end
    end
    lim_d = full_d ? `DSS_LIM_FULL : phase_d;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_cnt_q <= 11'h000;
      tot_q    <= 12'h000;
      phase_q  <= `DSS_LIM_FIRST;
      full_q   <= 1'b0;
      lim_q    <= `DSS_LIM_FIRST;
    end else begin
      ph_cnt_q <= ph_cnt_d;
      tot_q    <= tot_d;
      phase_q  <= phase_d;
      full_q   <= full_d;
      lim_q    <= lim_d;
    end
  end

  assign limit_sel = lim_q;
  assign full      = full_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  phase_reset_a: assert property (!run |=>
                                  lim_q == `DSS_LIM_FIRST && !full_q)
    else $error("soft-start not back in first phase");
  reg_full_a: assert property (run && in_reg |=> lim_q == `DSS_LIM_FULL)
    else $error("full limit not taken at regulation");
  step_size_a: assert property (run && $changed(lim_q) && !full_q |->
                                lim_q == $past(lim_q) + 2'h1)
    else $error("soft-start stepped by more than a quarter");
  ss_full_c: cover property (run && !in_reg ##1 $rose(full_q));
endmodule // dss_soft_start

// [tb/dss_analog_model.sv]
// comparator stand-in for the sequencer's far side
// assumes the bench sets the load demand; one clock
`timescale 1ns/1ps
module dss_analog_model #(
  parameter int RAMP   = 20,
  parameter int SETTLE = 50
) (
  // clock
  input  wire logic clk,
  // design drives
  input  wire logic boost_switch_on,
  input  wire logic neg_pump_enable,
  input  wire logic pos_pump_enable,
  // load from the bench
  input  wire logic demand,
  // comparators
  output logic      main_low_cmp,
  output logic      current_trip_cmp,
  output logic      neg_pump_feedback_ok,
  output logic      pos_pump_feedback_ok
);
  int on_q  = 0;
  int neg_q = 0;
  int pos_q = 0;
  // inductor ramp and pump settling, counted in clocks
  always @(posedge clk) begin
    on_q  <= boost_switch_on ? on_q + 1 : 0;
    neg_q <= neg_pump_enable ? neg_q + 1 : 0;
    pos_q <= pos_pump_enable ? pos_q + 1 : 0;
  end
  assign main_low_cmp         = demand;
  assign current_trip_cmp     = on_q >= RAMP;
  assign neg_pump_feedback_ok = neg_q >= SETTLE;
  assign pos_pump_feedback_ok = pos_q >= SETTLE;
endmodule // dss_analog_model

// [tb/tb.sv]
// self-checking bench of the display supply sequencer
// assumes the comparator model beside it; 100 MHz clock
`timescale 1ns/1ps
module tb;
  logic        clk = 0;
  logic        sys_rst = 1;
  logic        shutdown_low_input = 0;
  logic        pwm_cmp = 0;
  logic        fault_cmp = 0;
  logic        boost_in_reg = 0;
  logic        demand = 0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, d;
  logic        main_low_cmp, current_trip_cmp, fault_prev, ph_q;
  logic        neg_pump_feedback_ok, pos_pump_feedback_ok;
  logic        ref_enable, boost_enable, ldo_enable, boost_switch_on;
  logic [1:0]  current_limit_sel;
  logic        full_switch_current_limit, neg_pump_enable;
  logic        pos_pump_enable, pos_pump_low_on, pos_pump_high_on;
  logic        neg_pump_high_on, neg_pump_low_on, ready_low_out;
  logic        ready_low_oe, backplane_buffer_enable;
  int          mismatches = 0;
  int          compares = 0;
  int          n, r;
  logic [31:0] seed = 32'ha17c423f;

  always #5 clk = ~clk;

  dss_sequencer DUT (.clk, .sys_rst, .shutdown_low_input, .main_low_cmp,
    .current_trip_cmp, .pwm_cmp, .neg_pump_feedback_ok,
    .pos_pump_feedback_ok, .fault_cmp, .boost_in_reg, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_enable, .boost_enable,
    .ldo_enable, .boost_switch_on, .current_limit_sel,
    .full_switch_current_limit, .neg_pump_enable, .pos_pump_enable,
    .pos_pump_low_on, .pos_pump_high_on, .neg_pump_high_on,
    .neg_pump_low_on, .ready_low_out, .ready_low_oe,
    .backplane_buffer_enable);

  dss_analog_model PARTNER (.clk, .boost_switch_on, .neg_pump_enable,
    .pos_pump_enable, .demand, .main_low_cmp, .current_trip_cmp,
    .neg_pump_feedback_ok, .pos_pump_feedback_ok);

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] off_word();
    return {ref_enable, boost_enable, ldo_enable, neg_pump_enable,
            pos_pump_enable, ready_low_oe, backplane_buffer_enable, 1'b0};
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize;
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    tk(2);
    chk("off outputs", off_word(), 8'h00);
    wr(8'h00, 8'hfe);
    rd(8'h00);
    chk("ctrl", d, 8'h02);
    tk(1);
    chk("rdata idle", reg_rdata, 8'h00);
    seed = xs(seed);
    wr(8'h10, seed[7:0]);
    rd(8'h10);
    chk("unmapped", d, 8'h00);
    $display("test registers done");
    @(posedge clk);
    shutdown_low_input <= 1'b1;
    tk(6);
    chk("ref first", {ref_enable, boost_enable}, 8'h02);
    for (n = 0; n < 150 && boost_enable !== 1'b1; n++) tk(1);
    chk("boost on", {boost_enable, ldo_enable}, 8'h03);
    chk("first limit", current_limit_sel, 8'h00);
    seed = xs(seed);
    r = 0;
    for (n = 0; n < 200 + seed[7:0]; n++) begin
      tk(1);
      r += boost_switch_on;
    end
    chk("skip pulses", r, 8'h00);
    @(posedge clk);
    demand <= 1'b1;
    for (n = 0; n < 130 && boost_switch_on !== 1'b1; n++) tk(1);
    chk("switch set", boost_switch_on, 8'h01);
    for (n = 0; n < 40 && current_trip_cmp !== 1'b1; n++) tk(1);
    tk(4);
    chk("switch trip", boost_switch_on, 8'h00);
    tk(40);
    chk("switch held", boost_switch_on, 8'h00);
    @(posedge clk);
    demand <= 1'b0;
    boost_in_reg <= 1'b1;
    tk(6);
    chk("full limit", {current_limit_sel, full_switch_current_limit},
        8'h07);
    $display("test boost done");
    @(posedge clk);
    pwm_cmp <= 1'b1;
    tk(6);
    chk("neg pump", {neg_pump_enable, pos_pump_enable}, 8'h02);
    for (n = 0; n < 100 && pos_pump_enable !== 1'b1; n++) tk(1);
    chk("pos pump", pos_pump_enable, 8'h01);
    n = 0;
    r = 0;
    ph_q = pos_pump_high_on;
    repeat (400) begin
      tk(1);
      if (pos_pump_low_on === pos_pump_high_on) n++;
      if (neg_pump_high_on !== pos_pump_low_on) n++;
      if (neg_pump_low_on !== pos_pump_high_on) n++;
      if (pos_pump_high_on && !ph_q) r++;
      ph_q = pos_pump_high_on;
    end
    chk("pump phases", n, 8'h00);
    chk("pump rate", r, 8'h02);
    for (n = 0; n < 100 && ready_low_oe !== 1'b1; n++) tk(1);
    chk("ready", {ready_low_oe, backplane_buffer_enable, ready_low_out},
        8'h06);
    $display("test sequence done");
    @(posedge clk);
    fault_cmp <= 1'b1;
    tk(6);
    chk("fault", off_word(), 8'h80);
    rd(8'h04);
    chk("fault status", {d[5], d[2:0]}, 8'h0e);
    @(posedge clk);
    shutdown_low_input <= 1'b0;
    fault_cmp <= 1'b0;
    tk(6);
    chk("shutdown", off_word(), 8'h00);
    @(posedge clk);
    shutdown_low_input <= 1'b1;
    tk(6);
    chk("restart", ref_enable, 8'h01);
    for (n = 0; n < 150 && boost_enable !== 1'b1; n++) tk(1);
    rd(8'h04);
    chk("fault clear", {d[5], d[2:0]}, 8'h02);
    $display("test fault done");
    summarize;
  end
endmodule // tb
